// [design/esr_pkg.sv]
// Constants shared by the strap test and subsystem code register block.
// Assumes a byte-addressed 256-byte configuration window behind Wishbone.
package esr_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          SEL_W        = 4;
    localparam logic [7:0]  OFS_EE_TEST  = 8'hCC;
    localparam logic [7:0]  OFS_SUBSYS   = 8'hF0;
    localparam int          WORD_LSB     = 2;

    // ****************************************
    // Test and subsystem register field positions
    // ****************************************
    localparam int          BIT_RSVD_HI  = 31;
    localparam int          BIT_RSVD_LO  = 30;
    localparam int          BIT_LSB_ORD  = 29;
    localparam int          BIT_NORM_SPD = 28;
    localparam int          BIT_LOAD_EN  = 27;
    localparam int          BIT_LOAD_OK  = 26;
    localparam int          BIT_RSVD_25  = 25;
    localparam int          BIT_LOAD_DIS = 24;
    localparam int          VEND_LO      = 0;
    localparam int          VEND_HI      = 15;
    localparam int          DEV_LO       = 16;
    localparam int          DEV_HI       = 31;

    // ****************************************
    // Reset values and strap lines
    // ****************************************
    localparam logic        RST_LOAD_OK  = 1'b0;
    localparam logic        RST_LOAD_DIS = 1'b1;
    localparam logic        RST_STRAP    = 1'b0;
    localparam int          STRAP_W      = 3;
    localparam int          GNT_LSB_ORD  = 2;
    localparam int          GNT_NORM_SPD = 1;
    localparam int          GNT_LOAD_EN  = 0;
    localparam logic [1:0]  STRAP_SETTLE = 2'h2;
    localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;

    // Arbitrary neutral identity codes, not tied to any maker
    localparam logic [15:0] VEND_DFLT    = 16'hA5A5;
    localparam logic [15:0] DEV_DFLT     = 16'h5A5A;

    typedef enum logic [1:0] {
        ESR_ST_SETTLE,
        ESR_ST_HOLD
    } esr_strap_e;

endpackage

// [design/esr_regs.sv]
// Read-only strap test register and subsystem code register on Wishbone.
// Assumes grant pins arrive asynchronously and the autoload engine sits on clk_sys_i.
// What this block does
// - Test register bits 31:30 read zero and reset to zero.
// - Bit 29 picks EEPROM bit order: 0 MSB first (test), 1 LSB first.
// - Bit 29 captured from secondary grant line 2 after reset; not writable.
// - Bit 28 autoload speed: 0 fast, 1 normal (test); from grant line 1.
// - Bit 27 autoload bypass: 0 bypassed (test), 1 autoload; from grant line 0.
// - Bit 26 reads 1 only after a successful autoload; resets to 0.
// - Bit 25 reserved, reads zero, resets to zero.
// - Bit 24 shows autoload disabled when 1; resets to 1.
// - Offset F0h bits 15:0 read vendor code; autoload may replace, writes cannot.
// - Offset F0h bits 31:16 read device code; autoload may replace, writes cannot.
// - Primary and secondary side logic all run on the one primary clock, clk_sys_i.
//
// Implementation choice: the Wishbone register port.
module esr_regs
    import esr_pkg::*;
#(
    parameter logic [15:0] VEND_INIT = esr_pkg::VEND_DFLT, // Arbitrary default
    parameter logic [15:0] DEV_INIT  = esr_pkg::DEV_DFLT   // Arbitrary default
) (
    input  wire logic                        clk_sys_i,        // Primary clock
    input  wire logic                        rst_n_i,          // Async reset, active low
    input  wire logic                        wb_cyc_i,         // Bus cycle
    input  wire logic                        wb_stb_i,         // Bus strobe
    input  wire logic                        wb_we_i,          // Write enable
    input  wire logic [esr_pkg::ADDR_W-1:0]  wb_adr_i,         // Byte address
    input  wire logic [esr_pkg::SEL_W-1:0]   wb_sel_i,         // Byte lanes
    input  wire logic [esr_pkg::DATA_W-1:0]  wb_dat_i,         // Write data
    output logic      [esr_pkg::DATA_W-1:0]  wb_dat_o,         // Read data
    output logic                             wb_ack_o,         // Acknowledge
    input  wire logic [esr_pkg::STRAP_W-1:0] sec_grant_n_i,    // Secondary grant pins
    input  wire logic                        autoload_done_i,  // Autoload finished pulse
    input  wire logic                        autoload_ok_i,    // Autoload succeeded
    input  wire logic                        autoload_wr_i,    // Load new subsystem codes
    input  wire logic [15:0]                 autoload_vend_i,  // Loaded vendor code
    input  wire logic [15:0]                 autoload_dev_i,   // Loaded device code
    output logic                             ee_lsb_first_o,   // Bit order select
    output logic                             ee_normal_spd_o,  // Autoload speed select
    output logic                             ee_load_en_o,     // Autoload may start
    output logic                             strap_valid_o     // Straps captured
);
    import esr_pkg::*;

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic hit_word(input logic [ADDR_W-1:0] adr, input logic [ADDR_W-1:0] ofs);
        hit_word = (adr[ADDR_W-1:WORD_LSB] == ofs[ADDR_W-1:WORD_LSB]);
    endfunction

    // ****************************************
    // Strap synchroniser and capture
    // ****************************************
    logic [STRAP_W-1:0] grant_meta_r;
    logic [STRAP_W-1:0] grant_sync_r;
    logic [STRAP_W-1:0] strap_r;
    logic [1:0]         settle_r;
    esr_strap_e         strap_st_r;
    logic               load_dis_r;
    logic               load_ok_r;
    logic [15:0]        vend_r;
    logic [15:0]        dev_r;
    logic               req_w;
    logic [DATA_W-1:0]  rd_nxt;
    logic               rd_test_w;
    logic               rd_sub_w;

    // Pins are asynchronous; second stage alone feeds the capture
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_meta_r <= '0;
            grant_sync_r <= '0;
        end else begin
            grant_meta_r <= sec_grant_n_i;
            grant_sync_r <= grant_meta_r;
        end
    end

    // Capture waits for the synchroniser to fill after release, then freezes
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            settle_r   <= '0;
            strap_st_r <= ESR_ST_SETTLE;
            strap_r    <= {STRAP_W{RST_STRAP}};
        end else begin
            case (strap_st_r)
                ESR_ST_SETTLE: begin
                    if (settle_r == STRAP_SETTLE) begin
                        strap_r    <= grant_sync_r;
                        strap_st_r <= ESR_ST_HOLD;
                    end else begin
                        settle_r <= settle_r + 2'h1;
                    end
                end
                default: begin
                    strap_r <= strap_r;
                end
            endcase
        end
    end

    // ****************************************
    // Autoload state
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_dis_r <= RST_LOAD_DIS;
        end else if (strap_st_r == ESR_ST_SETTLE && settle_r == STRAP_SETTLE) begin
            load_dis_r <= ~grant_sync_r[GNT_LOAD_EN];
        end
    end

    // Success sticks until reset; a disabled autoload never reports success
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_ok_r <= RST_LOAD_OK;
        end else if (autoload_done_i && autoload_ok_i && !load_dis_r) begin
            load_ok_r <= 1'b1;
        end
    end

    // Only autoload reaches the codes; bus writes never do
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vend_r <= VEND_INIT;
            dev_r  <= DEV_INIT;
        end else if (autoload_wr_i && !load_dis_r) begin
            vend_r <= autoload_vend_i;
            dev_r  <= autoload_dev_i;
        end
    end

    // ****************************************
    // Control outputs
    // ****************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ee_lsb_first_o  <= RST_STRAP;
            ee_normal_spd_o <= RST_STRAP;
            ee_load_en_o    <= 1'b0;
            strap_valid_o   <= 1'b0;
        end else begin
            ee_lsb_first_o  <= strap_r[GNT_LSB_ORD];
            ee_normal_spd_o <= strap_r[GNT_NORM_SPD];
            ee_load_en_o    <= (strap_st_r == ESR_ST_HOLD) && !load_dis_r && !load_ok_r;
            strap_valid_o   <= (strap_st_r == ESR_ST_HOLD);
        end
    end

    // ****************************************
    // Wishbone slave
    // ****************************************
    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Read decodes shared by the read-back checks
    assign rd_test_w = req_w && !wb_we_i && hit_word(wb_adr_i, OFS_EE_TEST);
    assign rd_sub_w  = req_w && !wb_we_i && hit_word(wb_adr_i, OFS_SUBSYS);

    always_comb begin
        rd_nxt = DATA_ZERO;
        if (hit_word(wb_adr_i, OFS_EE_TEST)) begin
            rd_nxt[BIT_RSVD_HI:BIT_RSVD_LO] = '0;
            rd_nxt[BIT_LSB_ORD]  = strap_r[GNT_LSB_ORD];
            rd_nxt[BIT_NORM_SPD] = strap_r[GNT_NORM_SPD];
            rd_nxt[BIT_LOAD_EN]  = strap_r[GNT_LOAD_EN];
            rd_nxt[BIT_LOAD_OK]  = load_ok_r;
            rd_nxt[BIT_RSVD_25]  = 1'b0;
            rd_nxt[BIT_LOAD_DIS] = load_dis_r;
        end else if (hit_word(wb_adr_i, OFS_SUBSYS)) begin
            rd_nxt[VEND_HI:VEND_LO] = vend_r;
            rd_nxt[DEV_HI:DEV_LO]   = dev_r;
        end
    end

    // Every access is acked one cycle later; writes change nothing and unmapped reads return zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= DATA_ZERO;
        end else begin
            wb_ack_o <= req_w;
            if (req_w && !wb_we_i) begin
                wb_dat_o <= rd_nxt;
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    rsvd_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        req_w && !wb_we_i && hit_word(wb_adr_i, OFS_EE_TEST)
        |=> wb_ack_o && wb_dat_o[BIT_RSVD_HI:BIT_RSVD_LO] == 2'h0 && !wb_dat_o[BIT_RSVD_25])
        else $error("reserved test bits read nonzero");

    bit_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_valid_o |-> ee_lsb_first_o == strap_r[GNT_LSB_ORD])
        else $error("bit order output differs from strap");

    strap_cap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_st_r == ESR_ST_SETTLE && settle_r == STRAP_SETTLE |=> strap_r == $past(grant_sync_r))
        else $error("strap not captured from grant lines");

    speed_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_valid_o |-> ee_normal_spd_o == strap_r[GNT_NORM_SPD])
        else $error("speed output differs from strap");

    bypass_dis_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_st_r == ESR_ST_HOLD |-> load_dis_r == !strap_r[GNT_LOAD_EN])
        else $error("disable bit disagrees with bypass strap");

    load_ok_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(load_ok_r) |-> $past(autoload_done_i && autoload_ok_i && !load_dis_r))
        else $error("success set without successful autoload");

    dis_reset_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_st_r == ESR_ST_SETTLE |-> load_dis_r && !ee_load_en_o)
        else $error("autoload enabled before straps latched");

    vend_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !$past(autoload_wr_i) |-> $stable(vend_r))
        else $error("vendor code changed without autoload");

    dev_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !$past(autoload_wr_i) |-> $stable(dev_r))
        else $error("device code changed without autoload");

    strap_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(strap_st_r == ESR_ST_HOLD) |-> $stable(strap_r) && strap_st_r == ESR_ST_HOLD)
        else $error("strap bits moved after capture");

    // ****************************************
    // Read-back and hold checks
    // ****************************************
    // Read data is judged one edge after the request is taken, against the state sampled at the request edge
    rd_order_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> wb_dat_o[BIT_LSB_ORD] == $past(strap_r[GNT_LSB_ORD]))
        else $error("bit order read differs from captured strap");

    rd_speed_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> wb_dat_o[BIT_NORM_SPD] == $past(strap_r[GNT_NORM_SPD]))
        else $error("speed read differs from captured strap");

    rd_bypass_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> wb_dat_o[BIT_LOAD_EN] == $past(strap_r[GNT_LOAD_EN]))
        else $error("bypass read differs from captured strap");

    rd_status_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> wb_dat_o[BIT_LOAD_OK] == $past(load_ok_r))
        else $error("status read differs from success flag");

    rsvd_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> !wb_dat_o[BIT_RSVD_25] && wb_dat_o[BIT_LOAD_DIS-1:0] == '0)
        else $error("reserved test bits read nonzero");

    rd_disable_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_test_w |=> wb_dat_o[BIT_LOAD_DIS] == $past(load_dis_r))
        else $error("disable read differs from disable flag");

    rd_vend_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_sub_w |=> wb_dat_o[VEND_HI:VEND_LO] == $past(vend_r))
        else $error("vendor code read differs from register");

    rd_dev_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        rd_sub_w |=> wb_dat_o[DEV_HI:DEV_LO] == $past(dev_r))
        else $error("device code read differs from register");

    wr_inert_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        req_w && wb_we_i |=> $stable(wb_dat_o))
        else $error("write disturbed read data");

    ok_needs_en_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load_ok_r |-> !load_dis_r)
        else $error("success reported while autoload disabled");

    ok_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(load_ok_r) |-> load_ok_r)
        else $error("success flag cleared without reset");

    load_en_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ee_load_en_o |-> $past(!load_dis_r && !load_ok_r))
        else $error("autoload enabled while bypassed or done");

    sync_path_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        grant_sync_r == $past(grant_meta_r))
        else $error("grant synchroniser skipped a stage");

    dis_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(strap_st_r == ESR_ST_HOLD) |-> $stable(load_dis_r))
        else $error("disable bit moved after capture");

    out_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(strap_valid_o) |-> strap_valid_o && $stable(ee_lsb_first_o) && $stable(ee_normal_spd_o))
        else $error("strap outputs moved after capture");

    settle_lim_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        strap_st_r == ESR_ST_SETTLE |-> settle_r <= STRAP_SETTLE)
        else $error("settle count ran past capture point");

    vend_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(load_dis_r) |-> $stable(vend_r))
        else $error("vendor code loaded while autoload disabled");

    dev_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(load_dis_r) |-> $stable(dev_r))
        else $error("device code loaded while autoload disabled");

endmodule

// [test/esr_autoload_model.sv]
// Behavioural autoload engine that feeds the subsystem codes and the outcome.
// Assumes the register block's clock; go_i is a one-cycle command from the bench.
module esr_autoload_model (
    input  wire logic        clk_sys_i,  // Primary clock
    input  wire logic        rst_n_i,    // Async reset, active low
    input  wire logic        go_i,       // Start one load
    input  wire logic        ok_i,       // Outcome to report
    input  wire logic [31:0] codes_i,    // Device and vendor codes
    output logic             done_o,     // Load finished pulse
    output logic             ok_o,       // Load outcome
    output logic             wr_o,       // Code write pulse
    output logic [15:0]      vend_o,     // Vendor code
    output logic [15:0]      dev_o       // Device code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r;

    // Idle data lines toggle so a stale value is never mistaken for a load
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r  <= 4'h0;
            wr_o   <= 1'b0;
            done_o <= 1'b0;
            ok_o   <= 1'b0;
            vend_o <= 16'h0000;
            dev_o  <= 16'h0000;
        end else begin
            cnt_r  <= ((go_i || cnt_r != 4'h0) && cnt_r != 4'h4) ? cnt_r + 4'h1 : 4'h0;
            wr_o   <= (cnt_r == 4'h2);
            done_o <= (cnt_r == 4'h3);
            ok_o   <= (cnt_r == 4'h3) ? ok_i : ~ok_o;
            vend_o <= (cnt_r == 4'h2) ? codes_i[15:0] : ~vend_o;
            dev_o  <= (cnt_r == 4'h2) ? codes_i[31:16] : ~dev_o;
        end
    end
endmodule

// [test/eeprom_strap_test_and_subsystem_device_code_regs_test.sv]
// Self-checking bench for the strap test and subsystem code registers.
// Assumes one clock; the bench is the Wishbone master and drives the grant straps.
module eeprom_strap_test_and_subsystem_device_code_regs_test
    import esr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0, wb_ack_o, go = 1'b0, ok_cfg = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, codes = 32'h0;
    logic [2:0]  sec_grant_n_i = 3'h0;
    logic        autoload_done_i, autoload_ok_i, autoload_wr_i;
    logic [15:0] autoload_vend_i, autoload_dev_i;
    logic        ee_lsb_first_o, ee_normal_spd_o, ee_load_en_o, strap_valid_o;
    int          error_cnt = 0, n_tests = 0, cyc_cnt = 0;

    esr_regs i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sec_grant_n_i(sec_grant_n_i), .autoload_done_i(autoload_done_i),
        .autoload_ok_i(autoload_ok_i), .autoload_wr_i(autoload_wr_i), .autoload_vend_i(autoload_vend_i),
        .autoload_dev_i(autoload_dev_i), .ee_lsb_first_o(ee_lsb_first_o), .ee_normal_spd_o(ee_normal_spd_o),
        .ee_load_en_o(ee_load_en_o), .strap_valid_o(strap_valid_o));
    esr_autoload_model i_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .go_i(go), .ok_i(ok_cfg),
        .codes_i(codes), .done_o(autoload_done_i), .ok_o(autoload_ok_i), .wr_o(autoload_wr_i),
        .vend_o(autoload_vend_i), .dev_o(autoload_dev_i));

    always #5 clk_sys_i = ~clk_sys_i;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'($urandom);
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    function automatic logic [31:0] exp_test(input logic [2:0] s, input logic good);
        exp_test = {2'b00, s, good & s[0], 1'b0, ~s[0], 24'h00_0000};
    endfunction

    always @(posedge clk_sys_i) begin
        cyc_cnt++;
        if (cyc_cnt >= 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] rd, f0_exp, c;
        logic [2:0]  s;
        logic        good;
        rd = $urandom(32'h9275F88B);
        // All eight strap patterns, then random ones; success and failure both
        for (int i = 0; i < 11; i++) begin
            s = (i < 8) ? i[2:0] : 3'($urandom);
            good = (i[1:0] != 2'b01);
            c = $urandom;
            f0_exp = s[0] ? c : {DEV_DFLT, VEND_DFLT};
            @(posedge clk_sys_i);
            rst_n_i <= 1'b0;
            sec_grant_n_i <= s;
            repeat (4) @(posedge clk_sys_i);
            check("valid in reset", {31'h0, strap_valid_o}, 32'h0);
            rst_n_i <= 1'b1;
            bus(1'b0, OFS_EE_TEST, 32'h0, rd);
            check("test before capture", rd, 32'h0100_0000);
            for (int k = 0; k < 10 && strap_valid_o !== 1'b1; k++) @(negedge clk_sys_i);
            check("valid after capture", {31'h0, strap_valid_o}, 32'h1);
            check("outputs", {ee_lsb_first_o, ee_normal_spd_o, ee_load_en_o}, s);
            bus(1'b0, OFS_EE_TEST, 32'h0, rd);
            check("test straps", rd, exp_test(s, 1'b0));
            // Load is commanded even when bypassed, which must be ignored
            go <= 1'b1;
            ok_cfg <= good;
            codes <= c;
            @(posedge clk_sys_i);
            go <= 1'b0;
            for (int k = 0; k < 20 && autoload_done_i !== 1'b1; k++) @(negedge clk_sys_i);
            check("load finished", {31'h0, autoload_done_i}, 32'h1);
            @(posedge clk_sys_i);
            sec_grant_n_i <= ~s;
            bus(1'b0, OFS_EE_TEST, 32'h0, rd);
            check("test after load", rd, exp_test(s, good));
            check("load enable", {31'h0, ee_load_en_o}, {31'h0, s[0] & ~good});
            bus(1'b0, OFS_SUBSYS, 32'h0, rd);
            check("codes", rd, f0_exp);
            bus(1'b1, OFS_EE_TEST, $urandom, rd);
            bus(1'b1, OFS_SUBSYS, $urandom, rd);
            bus(1'b0, OFS_EE_TEST, 32'h0, rd);
            check("test after write", rd, exp_test(s, good));
            bus(1'b0, OFS_SUBSYS, 32'h0, rd);
            check("codes after write", rd, f0_exp);
            bus(1'b1, 8'(8'h40 + 4 * i), $urandom, rd);
            bus(1'b0, 8'(8'h40 + 4 * i), 32'h0, rd);
            check("unmapped", rd, DATA_ZERO);
        end
        report_and_stop();
    end
endmodule
